// ===== inc/scsi_irq_pkg.sv
package scsi_irq_pkg;

	// ********************************
	// Register offsets
	// ********************************
	localparam logic [7:0] ADDR_DATA_LATCH_LOW = 8'h06;
	localparam logic [7:0] ADDR_COUNT_0        = 8'h08;
	localparam logic [7:0] ADDR_STATUS_FIRST   = 8'h0B;
	localparam logic [7:0] ADDR_STATUS_SECOND  = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_EN_FIRST   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_EN_SECOND  = 8'h11;

	// ********************************
	// Field positions
	// ********************************
	localparam int BIT_TARGET      = 7;
	localparam int BIT_SEL_OUT     = 6;
	localparam int BIT_SEL_IN      = 5;
	localparam int BIT_SEL_PROG    = 4;
	localparam int BIT_WRAP        = 3;
	localparam int BIT_SIDE_DONE   = 2;
	localparam int BIT_PIO_READY   = 1;
	localparam int BIT_SEL_TIMEOUT = 7;
	localparam int BIT_ATN         = 6;
	localparam int BIT_BUS_RESET   = 5;
	localparam int BIT_PHASE_MIS   = 4;
	localparam int BIT_BUS_FREE    = 3;
	localparam int BIT_PARITY      = 2;
	localparam int BIT_PHASE_CHG   = 1;
	localparam int BIT_REQ_SEEN    = 0;

	// ********************************
	// Reset values and timing
	// ********************************
	localparam logic [7:0] BYTE_ZERO     = 8'h00;
	localparam logic [7:0] EN_FIRST_MASK = 8'h7F;
	localparam int COUNT_WIDTH    = 24;
	localparam int BUS_FREE_NS    = 400;
	localparam int CLK_PERIOD_NS  = 40;
	localparam int BUS_FREE_CYCLES = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ********************************
	// Carriers
	// ********************************
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic       bsy;
		logic       sel;
		logic       req;
		logic       ack;
		logic       atn;
		logic       rst;
		logic [2:0] phase;
	} scsi_bus_t;

	typedef struct packed {
		logic       wrap_enable;
		logic       scsi_dma_enable;
		logic       auto_pio_enable;
		logic       parity_check_enable;
		logic       host_side_done;
		logic       sending;
		logic [2:0] expected_phase;
	} ctrl_t;

	typedef struct packed {
		logic arb_won;
		logic sel_out_ok;
		logic selected_in;
		logic target_role;
		logic sel_timeout;
		logic atn_assert;
		logic last_xfer_done;
		logic byte_done;
		logic parity_err;
	} evt_t;

endpackage

// ===== logic/bus_free_detect.sv
`timescale 1ns/1ps
module bus_free_detect
	import scsi_irq_pkg::*;
#(
	parameter int CYCLES = BUS_FREE_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_bsy,
	input  wire logic i_sel,
	output logic      o_bus_free
);
	typedef enum logic [1:0] {BF_BUSY, BF_WAIT, BF_FREE} bf_state_t;
	typedef struct packed {
		bf_state_t   fsm;
		logic [15:0] cnt;
	} bf_t;

	bf_t st_reg;
	bf_t st_next;

	// ********************************
	// Idle timer: both lines low for the full window
	// ********************************
	always_comb begin
		st_next = st_reg;
		if (i_bsy || i_sel) begin
			st_next.fsm = BF_BUSY;
			st_next.cnt = 16'h0000;
		end else begin
			unique case (st_reg.fsm)
				BF_BUSY: begin
					st_next.fsm = BF_WAIT;
					st_next.cnt = 16'h0001;
				end
				BF_WAIT: begin
					st_next.cnt = st_reg.cnt + 16'h0001;
					if (st_reg.cnt >= 16'(CYCLES - 1))
						st_next.fsm = BF_FREE; // [RULE19]
				end
				BF_FREE: st_next.fsm = BF_FREE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			st_reg <= '{fsm: BF_BUSY, cnt: 16'h0000};
		else
			st_reg <= st_next;
	end

	assign o_bus_free = (st_reg.fsm == BF_FREE);
endmodule // bus_free_detect

// ===== logic/transfer_counter.sv
`timescale 1ns/1ps
module transfer_counter
	import scsi_irq_pkg::*;
#(
	parameter int W = COUNT_WIDTH
) (
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	input  wire reg_req_t     i_reg,
	input  wire logic         i_wrap_enable,
	input  wire logic         i_byte_done,
	output logic [W-1:0]      o_count,
	output logic              o_wrap_pulse,
	output logic              o_nonzero_write
);
	typedef struct packed {
		logic [W-1:0] count;
		logic         wrap;
		logic         nz_wr;
	} cnt_t;

	cnt_t st_reg;
	cnt_t st_next;

	// ********************************
	// Byte loads win over a count step
	// ********************************
	always_comb begin
		logic hit;
		hit = 1'b0;
		st_next = st_reg;
		st_next.wrap = 1'b0;
		st_next.nz_wr = 1'b0;
		for (int b = 0; b < W / 8; b++) begin
			if (i_reg.wr && i_reg.addr == ADDR_COUNT_0 + 8'(b)) begin
				st_next.count[b*8 +: 8] = i_reg.wdata;
				hit = 1'b1;
			end
		end
		if (hit)
			st_next.nz_wr = |st_next.count;
		else if (i_byte_done) begin
			// Without wrap the count sticks at zero
			if (st_reg.count != '0 || i_wrap_enable) begin // [RULE7]
				st_next.count = st_reg.count - W'(1);
				st_next.wrap = (st_reg.count == '0); // [RULE7]
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_count = st_reg.count;
	assign o_wrap_pulse = st_reg.wrap;
	assign o_nonzero_write = st_reg.nz_wr;
endmodule // transfer_counter

// ===== logic/scsi_interrupt_status_clear.sv
// Operation
// RULE1 - First status readable regardless of enables
// RULE2 - Set and enabled raises irq; target excluded
// RULE3 - Bit 7 shows target role
// RULE4 - Selection-out done; clears on bus free
// RULE5 - Selected-in; clears on bus free or write
// RULE6 - Selecting sets on arbitration, clears on done
// RULE7 - Counter wraps only with wrap enable
// RULE8 - Wrap also on DMA, zero count, wrap
// RULE9 - Side done on final transfer or pio ready
// RULE10 - Side done cleared by count, wrap, DMA
// RULE11 - Controller drops transfer enable before clearing
// RULE12 - Pio ready on REQ or ACK edge
// RULE13 - Pio ready cleared by latch access, clears
// RULE14 - Transfer done is host AND side done
// RULE15 - Second clear bits clear on one only
// RULE16 - Second clear bit map; bit 4 unused
// RULE17 - Clear bit 6 clears ATN drive/seen
// RULE18 - Second status readable; enabled bits interrupt
// RULE19 - Bus free latched after 400 ns idle
// RULE20 - Phase mismatch clears on match or req clear
// RULE21 - Parity latched when checking, else zero
// RULE22 - Irq is OR; all status reset zero
`timescale 1ns/1ps
module scsi_interrupt_status_clear
	import scsi_irq_pkg::*;
#(
	parameter int W = COUNT_WIDTH
) (
	input  wire logic      i_clk,
	input  wire logic      i_sys_rst,
	input  wire reg_req_t  i_reg,
	input  wire scsi_bus_t i_bus,
	input  wire ctrl_t     i_ctrl,
	input  wire evt_t      i_evt,
	output logic [7:0]     o_reg_rdata,
	output logic           o_scsi_irq_out,
	output logic           o_atn_drive
);
	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic       sel_out_done;
		logic       selected_in;
		logic       sel_in_progress;
		logic       counter_wrap;
		logic       scsi_side_done;
		logic       done_by_pio;
		logic       pio_ready;
		logic       selection_timeout;
		logic       atn_seen;
		logic       bus_reset_seen;
		logic       phase_mismatch;
		logic       bus_free_seen;
		logic       parity_error;
		logic       phase_change;
		logic       req_seen;
		logic       atn_drive;
		logic [7:0] irq_en_first;
		logic [7:0] irq_en_second;
		logic [7:0] rdata;
		logic       irq;
		logic       prev_req;
		logic       prev_ack;
		logic       prev_bus_free;
		logic       prev_wrap_en;
		logic       prev_dma_en;
		logic       prev_pio_en;
		logic [2:0] prev_phase;
	} state_t;

	state_t       st_reg;
	state_t       st_next;
	logic [W-1:0] count;
	logic         wrap_pulse;
	logic         nonzero_write;
	logic         bus_free;
	logic [7:0]   status_first;
	logic [7:0]   status_second;

	// Register write strobe for one offset
	function automatic logic wr_at(input reg_req_t r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// Register read strobe for one offset
	function automatic logic rd_at(input reg_req_t r, input logic [7:0] a);
		return r.rd && (r.addr == a);
	endfunction

	// ********************************
	// Helpers
	// ********************************
	transfer_counter #(
		.W(W)
	) u_counter (
		.i_clk          (i_clk),
		.i_sys_rst      (i_sys_rst),
		.i_reg          (i_reg),
		.i_wrap_enable  (i_ctrl.wrap_enable),
		.i_byte_done    (i_evt.byte_done),
		.o_count        (count),
		.o_wrap_pulse   (wrap_pulse),
		.o_nonzero_write(nonzero_write)
	);

	bus_free_detect #(
		.CYCLES(BUS_FREE_CYCLES)
	) u_bus_free (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_bsy     (i_bus.bsy),
		.i_sel     (i_bus.sel),
		.o_bus_free(bus_free)
	);

	// ********************************
	// Status views
	// ********************************
	// Read straight from the flags; enables never mask the view
	always_comb begin
		status_first = BYTE_ZERO; // [RULE1]
		status_first[BIT_TARGET]    = i_evt.target_role; // [RULE3]
		status_first[BIT_SEL_OUT]   = st_reg.sel_out_done;
		status_first[BIT_SEL_IN]    = st_reg.selected_in;
		status_first[BIT_SEL_PROG]  = st_reg.sel_in_progress;
		status_first[BIT_WRAP]      = st_reg.counter_wrap;
		status_first[BIT_SIDE_DONE] = st_reg.scsi_side_done;
		status_first[BIT_PIO_READY] = st_reg.pio_ready;
		status_first[0] = i_ctrl.host_side_done & st_reg.scsi_side_done; // [RULE14]
	end

	// Parity reads zero whenever checking is off
	always_comb begin
		status_second = BYTE_ZERO; // [RULE18]
		status_second[BIT_SEL_TIMEOUT] = st_reg.selection_timeout;
		status_second[BIT_ATN]         = st_reg.atn_seen;
		status_second[BIT_BUS_RESET]   = st_reg.bus_reset_seen;
		status_second[BIT_PHASE_MIS]   = st_reg.phase_mismatch;
		status_second[BIT_BUS_FREE]    = st_reg.bus_free_seen;
		status_second[BIT_PARITY] = st_reg.parity_error & i_ctrl.parity_check_enable; // [RULE21]
		status_second[BIT_PHASE_CHG]   = st_reg.phase_change;
		status_second[BIT_REQ_SEEN]    = st_reg.req_seen;
	end

	// ********************************
	// Next state
	// ********************************
	// Clears are applied first, sets afterwards, so an event in the
	// cycle of its clear is never lost.
	always_comb begin
		logic [7:0] clr1;
		logic [7:0] clr2;
		logic       bf_rise;
		logic       req_rise;
		logic       ack_rise;
		logic       pio_latch;
		logic       pio_clr;
		logic       req_clr;
		logic       zero;
		clr1 = wr_at(i_reg, ADDR_STATUS_FIRST) ? i_reg.wdata : BYTE_ZERO;
		clr2 = wr_at(i_reg, ADDR_STATUS_SECOND) ? i_reg.wdata : BYTE_ZERO; // [RULE15]
		bf_rise = bus_free && !st_reg.prev_bus_free;
		req_rise = i_bus.req && !st_reg.prev_req;
		ack_rise = i_bus.ack && !st_reg.prev_ack;
		pio_latch = 1'b0;
		pio_clr = 1'b0;
		req_clr = 1'b0;
		zero = (count == '0);
		st_next = st_reg;

		// Edge history
		st_next.prev_req = i_bus.req;
		st_next.prev_ack = i_bus.ack;
		st_next.prev_bus_free = bus_free;
		st_next.prev_wrap_en = i_ctrl.wrap_enable;
		st_next.prev_dma_en = i_ctrl.scsi_dma_enable;
		st_next.prev_pio_en = i_ctrl.auto_pio_enable;
		st_next.prev_phase = i_bus.phase;

		// Enable registers
		if (wr_at(i_reg, ADDR_IRQ_EN_FIRST))
			st_next.irq_en_first = i_reg.wdata & EN_FIRST_MASK;
		if (wr_at(i_reg, ADDR_IRQ_EN_SECOND))
			st_next.irq_en_second = i_reg.wdata;

		// Selection flags
		if (clr1[BIT_SEL_OUT] || bf_rise) st_next.sel_out_done = 1'b0; // [RULE4]
		if (clr1[BIT_SEL_IN] || bf_rise) st_next.selected_in = 1'b0; // [RULE5]
		if (clr1[BIT_SEL_PROG] || i_evt.sel_out_ok)
			st_next.sel_in_progress = 1'b0; // [RULE6]
		if (i_evt.sel_out_ok) st_next.sel_out_done = 1'b1; // [RULE4]
		if (i_evt.selected_in) st_next.selected_in = 1'b1; // [RULE5]
		if (i_evt.arb_won) st_next.sel_in_progress = 1'b1; // [RULE6]

		// Counter wrap
		if (clr1[BIT_WRAP]) st_next.counter_wrap = 1'b0; // [RULE8]
		if (wrap_pulse) st_next.counter_wrap = 1'b1; // [RULE7]
		if (i_ctrl.scsi_dma_enable && zero && i_ctrl.wrap_enable)
			st_next.counter_wrap = 1'b1; // [RULE8]

		// Pio ready: latch access in the transfer direction clears it
		pio_latch = i_ctrl.sending ? wr_at(i_reg, ADDR_DATA_LATCH_LOW)
			: rd_at(i_reg, ADDR_DATA_LATCH_LOW);
		pio_clr = pio_latch || clr1[BIT_PIO_READY]
			|| (st_reg.prev_pio_en && !i_ctrl.auto_pio_enable); // [RULE13]
		if (pio_clr)
			st_next.pio_ready = 1'b0; // [RULE13]
		if (i_ctrl.auto_pio_enable
			&& (i_evt.target_role ? ack_rise : req_rise))
			st_next.pio_ready = 1'b1; // [RULE12]

		// Side done; the firmware must stop transfers before this clear
		if (nonzero_write
			|| (i_ctrl.wrap_enable && !st_reg.prev_wrap_en)
			|| (!i_ctrl.scsi_dma_enable && st_reg.prev_dma_en)
			|| (st_reg.done_by_pio && st_reg.pio_ready && !st_next.pio_ready)) begin
			st_next.scsi_side_done = 1'b0; // [RULE10]
			st_next.done_by_pio = 1'b0;
		end
		if (zero && !i_ctrl.wrap_enable && i_evt.last_xfer_done
			&& (i_ctrl.scsi_dma_enable || i_ctrl.auto_pio_enable))
			st_next.scsi_side_done = 1'b1; // [RULE9]
		if (st_next.pio_ready && !st_reg.pio_ready) begin
			st_next.scsi_side_done = 1'b1; // [RULE9]
			st_next.done_by_pio = 1'b1;
		end

		// Second group clears
		if (clr2[BIT_SEL_TIMEOUT]) st_next.selection_timeout = 1'b0; // [RULE16]
		if (clr2[BIT_BUS_RESET]) st_next.bus_reset_seen = 1'b0; // [RULE16]
		if (clr2[BIT_BUS_FREE]) st_next.bus_free_seen = 1'b0; // [RULE19]
		if (clr2[BIT_PARITY]) st_next.parity_error = 1'b0; // [RULE21]
		if (clr2[BIT_PHASE_CHG]) st_next.phase_change = 1'b0; // [RULE16]
		req_clr = clr2[BIT_REQ_SEEN] || ack_rise;
		if (req_clr) st_next.req_seen = 1'b0; // [RULE16]

		// ATN: one clear bit serves both roles
		if (clr2[BIT_ATN] && !i_evt.target_role) st_next.atn_drive = 1'b0; // [RULE17]
		if (bf_rise) st_next.atn_drive = 1'b0; // [RULE17]
		if ((clr2[BIT_ATN] && i_evt.target_role) || !i_bus.atn)
			st_next.atn_seen = 1'b0; // [RULE17]

		// Phase mismatch has no clear bit of its own
		if (i_ctrl.expected_phase == i_bus.phase || clr2[BIT_REQ_SEEN])
			st_next.phase_mismatch = 1'b0; // [RULE20]

		// Second group sets
		if (i_evt.sel_timeout) st_next.selection_timeout = 1'b1; // [RULE16]
		if (i_evt.atn_assert) st_next.atn_drive = 1'b1; // [RULE17]
		if (i_evt.target_role && i_bus.atn) st_next.atn_seen = 1'b1; // [RULE17]
		if (i_bus.rst) st_next.bus_reset_seen = 1'b1; // [RULE16]
		if (bus_free) st_next.bus_free_seen = 1'b1; // [RULE19]
		if (i_ctrl.parity_check_enable && i_evt.parity_err)
			st_next.parity_error = 1'b1; // [RULE21]
		if (i_bus.phase != st_reg.prev_phase && i_bus.phase != i_ctrl.expected_phase)
			st_next.phase_change = 1'b1;
		if (!i_evt.target_role && req_rise) begin
			st_next.req_seen = 1'b1;
			if (i_bus.phase != i_ctrl.expected_phase)
				st_next.phase_mismatch = 1'b1;
		end

		// Irq from both groups; target bit never counts
		st_next.irq = |(status_first[6:0] & st_reg.irq_en_first[6:0])
			| |(status_second & st_reg.irq_en_second); // [RULE2] [RULE18] [RULE22]

		// Read data; unmapped offsets answer zero
		if (i_reg.rd) begin
			st_next.rdata = BYTE_ZERO;
			if (i_reg.addr == ADDR_STATUS_FIRST)
				st_next.rdata = status_first; // [RULE1]
			if (i_reg.addr == ADDR_STATUS_SECOND)
				st_next.rdata = status_second; // [RULE18]
			if (i_reg.addr == ADDR_IRQ_EN_FIRST)
				st_next.rdata = st_reg.irq_en_first;
			if (i_reg.addr == ADDR_IRQ_EN_SECOND)
				st_next.rdata = st_reg.irq_en_second;
			for (int b = 0; b < W / 8; b++)
				if (i_reg.addr == ADDR_COUNT_0 + 8'(b))
					st_next.rdata = count[b*8 +: 8];
		end
	end

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			st_reg <= '0; // [RULE22]
		else
			st_reg <= st_next;
	end

	assign o_reg_rdata = st_reg.rdata;
	assign o_scsi_irq_out = st_reg.irq;
	assign o_atn_drive = st_reg.atn_drive;

	// ********************************
	// Checks
	// ********************************
	property p_irq_enabled;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_reg.sel_out_done && st_reg.irq_en_first[BIT_SEL_OUT]) |=> o_scsi_irq_out;
	endproperty
	a_irq_enabled: assert property (p_irq_enabled) // [RULE2]
		else $error("enabled status did not raise irq");
	property p_irq_masked;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_reg.irq_en_first == BYTE_ZERO && st_reg.irq_en_second == BYTE_ZERO)
			|=> !o_scsi_irq_out;
	endproperty
	a_irq_masked: assert property (p_irq_masked) // [RULE22]
		else $error("irq raised with all enables off");
	property p_sel_prog_clear;
		@(posedge i_clk) disable iff (i_sys_rst)
		(i_evt.sel_out_ok && !i_evt.arb_won) |=> (st_reg.sel_out_done && !st_reg.sel_in_progress);
	endproperty
	a_sel_prog_clear: assert property (p_sel_prog_clear) // [RULE6]
		else $error("selecting flag survived selection done");
	property p_bus_free_clears_sel;
		@(posedge i_clk) disable iff (i_sys_rst)
		($rose(bus_free) && !i_evt.sel_out_ok) |=> !st_reg.sel_out_done;
	endproperty
	a_bus_free_clears_sel: assert property (p_bus_free_clears_sel) // [RULE4]
		else $error("selection done not cleared by bus free");
	property p_no_underflow;
		@(posedge i_clk) disable iff (i_sys_rst)
		(count == '0 && !i_ctrl.wrap_enable && i_evt.byte_done && !i_reg.wr)
			|=> (count == '0);
	endproperty
	a_no_underflow: assert property (p_no_underflow) // [RULE7]
		else $error("counter went below zero without wrap");
	property p_done_and;
		@(posedge i_clk) disable iff (i_sys_rst)
		rd_at(i_reg, ADDR_STATUS_FIRST)
			|=> o_reg_rdata[0] == ($past(i_ctrl.host_side_done) && $past(st_reg.scsi_side_done));
	endproperty
	a_done_and: assert property (p_done_and) // [RULE14]
		else $error("transfer done is not the AND of both dones");
	property p_parity_off;
		@(posedge i_clk) disable iff (i_sys_rst)
		(rd_at(i_reg, ADDR_STATUS_SECOND) && !i_ctrl.parity_check_enable)
			|=> !o_reg_rdata[BIT_PARITY];
	endproperty
	a_parity_off: assert property (p_parity_off) // [RULE21]
		else $error("parity read set with checking off");
	property p_pio_latch_clear;
		@(posedge i_clk) disable iff (i_sys_rst)
		(st_reg.pio_ready && i_ctrl.sending && wr_at(i_reg, ADDR_DATA_LATCH_LOW)
			&& !i_bus.req && !i_bus.ack) |=> !st_reg.pio_ready;
	endproperty
	a_pio_latch_clear: assert property (p_pio_latch_clear) // [RULE13]
		else $error("pio ready not cleared by latch write");
	property p_pio_sets_done;
		@(posedge i_clk) disable iff (i_sys_rst)
		$rose(st_reg.pio_ready) |-> st_reg.scsi_side_done;
	endproperty
	a_pio_sets_done: assert property (p_pio_sets_done) // [RULE9]
		else $error("pio ready did not set side done");
	property p_bus_free_latch;
		@(posedge i_clk) disable iff (i_sys_rst)
		(bus_free && !i_bus.bsy && !i_bus.sel) |=> st_reg.bus_free_seen [*2];
	endproperty
	a_bus_free_latch: assert property (p_bus_free_latch) // [RULE19]
		else $error("bus free not latched");
endmodule // scsi_interrupt_status_clear

// ===== sim/scsi_bus_partner.sv
`timescale 1ns/1ps
module scsi_bus_partner
	import scsi_irq_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_go_free,
	input  wire logic       i_rst_on,
	input  wire logic       i_req_on,
	input  wire logic [2:0] i_phase,
	output scsi_bus_t       o_bus
);
	// Bus starts owned so the idle timer cannot latch before the bench looks
	scsi_bus_t bus_reg = '{bsy: 1'b1, default: 1'b0};

	// Lines move only on the clock, as if seen through the pin synchronisers
	always @(posedge i_clk) begin
		bus_reg.bsy   <= ~i_go_free; // Released bus drops BSY; SEL is held low throughout
		bus_reg.sel   <= 1'b0;
		bus_reg.req   <= i_req_on & ~i_go_free; // No handshake on a free bus
		bus_reg.ack   <= 1'b0;
		bus_reg.atn   <= 1'b0;
		bus_reg.rst   <= i_rst_on;
		bus_reg.phase <= i_phase; // Target picks the phase the bench asks for
	end

	assign o_bus = bus_reg;
endmodule // scsi_bus_partner

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import scsi_irq_pkg::*;

	// ****************************************
	// Clock, reset and stimulus
	// ****************************************
	logic      clk       = 1'b0;
	logic      rst       = 1'b1;
	reg_req_t  reg_q     = '0;
	ctrl_t     ctrl_q    = '0;
	evt_t      evt_q     = '0;
	scsi_bus_t bus_w;
	logic      go_free   = 1'b0;
	logic      rst_on    = 1'b0;
	logic      req_on    = 1'b0;
	logic [2:0] phase_on = 3'h0;
	logic [7:0] rdata;
	logic      irq;
	logic      atn_drive;
	int        bad_count = 0;
	int        checks    = 0;

	always #20 clk = ~clk;

	scsi_bus_partner i_scsi_bus_partner (.i_clk(clk), .i_go_free(go_free), .i_rst_on(rst_on),
		.i_req_on(req_on), .i_phase(phase_on), .o_bus(bus_w));

	scsi_interrupt_status_clear i_scsi_interrupt_status_clear (.i_clk(clk), .i_sys_rst(rst),
		.i_reg(reg_q), .i_bus(bus_w), .i_ctrl(ctrl_q), .i_evt(evt_q), .o_reg_rdata(rdata),
		.o_scsi_irq_out(irq), .o_atn_drive(atn_drive));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Every task leaves the bench just after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask

	// One-cycle write, then a cycle for the effect to land in status
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_q = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		tick(1);
		reg_q = '0;
		tick(1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_q = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		tick(1);
		reg_q = '0;
		d = rdata;
		// Idle cycle so the next request never lands in this time step
		tick(1);
	endtask

	task automatic expect_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(name, exp, v);
	endtask

	// Mask bits follow the event carrier, arbitration won at the top
	task automatic pulse(input logic [8:0] m);
		evt_q = evt_t'(evt_q | m);
		tick(1);
		evt_q = evt_t'(evt_q & ~m);
		tick(2);
	endtask

	task automatic chk_irq(input logic exp);
		tick(2);
		chk("irq", {7'h00, exp}, {7'h00, irq});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic sc_selection();
		pulse(9'h100);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h10);
		wr(ADDR_IRQ_EN_FIRST, 8'h50);
		chk_irq(1'b1);
		pulse(9'h080);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h40);
		wr(ADDR_STATUS_FIRST, 8'h40);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h00);
		chk_irq(1'b0);
		evt_q.target_role = 1'b1;
		tick(2);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h80);
		wr(ADDR_IRQ_EN_FIRST, 8'hFF);
		expect_reg("irq_enable_first", ADDR_IRQ_EN_FIRST, 8'h7F);
		chk_irq(1'b0);
		evt_q.target_role = 1'b0;
		wr(ADDR_IRQ_EN_FIRST, 8'h00);
	endtask

	task automatic sc_bus_free();
		logic [7:0] v;
		logic       hit;
		hit = 1'b0;
		pulse(9'h040);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h20);
		go_free = 1'b1;
		for (int n = 0; n < 40 && !hit; n++) begin
			rd(ADDR_STATUS_SECOND, v);
			hit = v[BIT_BUS_FREE];
		end
		if (!hit) begin
			$display("unexpected bus_free expected 1 seen 0");
			bad_count++;
			close_out();
		end
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h00);
		go_free = 1'b0;
		tick(3);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h08);
		wr(ADDR_STATUS_SECOND, 8'h00);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h08);
		wr(ADDR_STATUS_SECOND, 8'h08);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h00);
	endtask

	task automatic sc_second();
		pulse(9'h010);
		rst_on = 1'b1;
		tick(2);
		rst_on = 1'b0;
		tick(2);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'hA0);
		wr(ADDR_IRQ_EN_SECOND, 8'h80);
		chk_irq(1'b1);
		wr(ADDR_STATUS_SECOND, 8'h5F);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'hA0);
		wr(ADDR_STATUS_SECOND, 8'h80);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h20);
		chk_irq(1'b0);
		wr(ADDR_STATUS_SECOND, 8'h20);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h00);
		wr(ADDR_IRQ_EN_SECOND, 8'h00);
		pulse(9'h001);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h00);
		ctrl_q.parity_check_enable = 1'b1;
		pulse(9'h001);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h04);
		wr(ADDR_STATUS_SECOND, 8'h04);
		ctrl_q.parity_check_enable = 1'b0;
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h00);
	endtask

	task automatic sc_counter();
		ctrl_q.wrap_enable = 1'b1;
		pulse(9'h002);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h08);
		wr(ADDR_STATUS_FIRST, 8'h08);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h00);
		ctrl_q.wrap_enable = 1'b0;
		for (int b = 0; b < 3; b++) wr(ADDR_COUNT_0 + 8'(b), 8'h00);
		pulse(9'h002);
		expect_reg("count_high", ADDR_COUNT_0 + 8'h02, 8'h00);
		ctrl_q.scsi_dma_enable = 1'b1;
		ctrl_q.host_side_done = 1'b1;
		tick(2);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h00);
		pulse(9'h004);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h05);
		ctrl_q.scsi_dma_enable = 1'b0; // Not in target role, nothing to stop first
		tick(2);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h00);
		ctrl_q.scsi_dma_enable = 1'b1;
		ctrl_q.wrap_enable = 1'b1;
		tick(2);
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h08);
		ctrl_q = '0;
		wr(ADDR_STATUS_FIRST, 8'h08);
	endtask

	task automatic sc_pio();
		logic [7:0] v;
		ctrl_q.auto_pio_enable = 1'b1;
		for (int k = 0; k < 3; k++) begin
			if (k == 2) ctrl_q.sending = 1'b1;
			req_on = 1'b1;
			tick(3);
			req_on = 1'b0;
			expect_reg("status_first", ADDR_STATUS_FIRST, 8'h06);
			if (k == 0) rd(ADDR_DATA_LATCH_LOW, v);
			else if (k == 1) wr(ADDR_STATUS_FIRST, 8'h02);
			else wr(ADDR_DATA_LATCH_LOW, 8'h00);
			tick(1);
			expect_reg("status_first", ADDR_STATUS_FIRST, 8'h00);
		end
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h01);
		wr(ADDR_STATUS_SECOND, 8'h01);
		ctrl_q.auto_pio_enable = 1'b0;
		phase_on = 3'h2;
		req_on = 1'b1;
		tick(3);
		req_on = 1'b0;
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h13);
		ctrl_q.expected_phase = 3'h2;
		tick(2);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h03);
		wr(ADDR_STATUS_SECOND, 8'h03);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h00);
		pulse(9'h008);
		chk("atn_drive", 8'h01, {7'h00, atn_drive});
		wr(ADDR_STATUS_SECOND, 8'h40);
		tick(1);
		chk("atn_drive", 8'h00, {7'h00, atn_drive});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		tick(2);
		rst = 1'b0;
		expect_reg("status_first", ADDR_STATUS_FIRST, 8'h00);
		expect_reg("status_second", ADDR_STATUS_SECOND, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
		sc_selection();
		sc_bus_free();
		sc_second();
		sc_counter();
		sc_pio();
		close_out();
	end
endmodule // tb_top
